/* core/selftest_timing_pkg.sv */
// Purpose: Shared constants for the self-test measurement timing block.
// Assumes: 40 MHz core clock, byte-wide register port.
// Notes: Each rule below has one tag; the logic that carries it out is marked with it.
// Operation
// (R1) The low nibble of the self-test decimation register holds the decimation code.
// (R2) Codes 0 to 12 give 2**code samples per phase, and codes 13 to 15 saturate at 4096.
// (R3) Each measurement period per axis and direction lasts 2**code times (312.5 us + idle*31.25 us).
// (R4) While self-test runs, the user data rate and power mode are replaced by self-test timing.
// (R5) When the axis select returns to 00b, the user data rate and power mode are restored.
// (R6) A 5-bit idle code sets the idle phase to 312.5 us plus code times 31.25 us.
// (R7) A phase result is produced only after the selected number of samples is accumulated.
package selftest_timing_pkg;
    localparam logic [7:0] DEC_CFG_ADDR   = 8'h38;
    localparam logic [7:0] IDLE_CFG_ADDR  = 8'h37;
    localparam logic [7:0] DEC_CFG_RESET  = 8'h00;
    localparam logic [7:0] IDLE_CFG_RESET = 8'h00;
    localparam int         DEC_LSB        = 0;
    localparam int         DEC_W          = 4;
    localparam int         IDLE_LSB       = 0;
    localparam int         IDLE_W         = 5;
    localparam logic [3:0] DEC_MAX_CODE   = 4'hC;
    localparam int         CNT_W          = 13;
    localparam int         CLK_KHZ        = 40000;
    // Times in nanoseconds: 312.5 us and 31.25 us.
    localparam int         BASE_NS        = 312500;
    localparam int         STEP_NS        = 31250;
    localparam int         BASE_CYC       = (BASE_NS * (CLK_KHZ / 1000)) / 1000;
    localparam int         STEP_CYC       = (STEP_NS * (CLK_KHZ / 1000)) / 1000;
    localparam logic [1:0] AXIS_OFF       = 2'h0;
endpackage : selftest_timing_pkg

/* core/selftest_sample_tick.sv */
// Purpose: Produces one sample tick per self-test sample slot.
// Assumes: Idle code is stable while running.
// Notes: Slot length is base plus idle steps, in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module selftest_sample_tick (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic [4:0] idle_code,
    output logic            tick
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] slot_len;

    always_comb
    begin
        slot_len = 16'(selftest_timing_pkg::BASE_CYC)
                 + 16'(idle_code) * 16'(selftest_timing_pkg::STEP_CYC); // [R6]
        tick     = run && (cnt_ff == slot_len - 16'h0001);
        nxt_cnt  = (!run || tick) ? 16'h0000 : cnt_ff + 16'h0001;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cnt_ff <= 16'h0000;
        else
            cnt_ff <= nxt_cnt;
    end
endmodule : selftest_sample_tick
`default_nettype wire

/* core/selftest_timing.sv */
// Purpose: Self-test measurement phase timing and user setting override.
// Assumes: Byte register port synchronous to clk; writes take one cycle.
// Notes: A phase ends after 2**code sample slots (4096 for codes above 12); result strobe marks its end.
`timescale 1ns/1ps
`default_nettype none
module selftest_timing (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic [1:0]  selftest_axis_select,
    input  wire logic [3:0]  user_output_data_rate,
    input  wire logic [1:0]  user_power_mode,
    input  wire logic [15:0] sample_in,
    output logic      [3:0]  output_data_rate,
    output logic      [1:0]  power_mode,
    output logic             selftest_active,
    output logic             sample_tick,
    output logic      [12:0] phase_samples,
    output logic      [27:0] phase_sum,
    output logic             phase_done
);
    // One-hot, so every state test is a single flop; the result state lasts one cycle.
    typedef enum logic [2:0]
    {
        PH_OFF     = 3'b001,
        PH_MEASURE = 3'b010,
        PH_RESULT  = 3'b100
    } phase_state_t;

    logic [7:0]   self_test_decimation_cfg_ff;
    logic [7:0]   nxt_self_test_decimation_cfg;
    logic [7:0]   idle_cfg_ff;
    logic [7:0]   nxt_idle_cfg;
    logic         dec_cfg_sel;
    logic         idle_cfg_sel;

    phase_state_t state_ff;
    phase_state_t nxt_state;
    logic [12:0]  cnt_ff;
    logic [12:0]  nxt_cnt;
    logic [27:0]  acc_ff;
    logic [27:0]  nxt_acc;
    logic [27:0]  sum_ff;
    logic [27:0]  nxt_sum;
    logic         done_ff;
    logic         nxt_done;

    logic [3:0]   dec_code;
    logic [4:0]   idle_code;
    logic [12:0]  target;
    logic         last_sample;
    logic [27:0]  sample_ext;
    logic         tick;

    assign dec_code = self_test_decimation_cfg_ff[selftest_timing_pkg::DEC_LSB +:
                                                  selftest_timing_pkg::DEC_W]; // [R1]
    assign idle_code = idle_cfg_ff[selftest_timing_pkg::IDLE_LSB +:
                                   selftest_timing_pkg::IDLE_W]; // [R6]
    assign dec_cfg_sel     = reg_wr && (reg_addr == selftest_timing_pkg::DEC_CFG_ADDR);
    assign idle_cfg_sel    = reg_wr && (reg_addr == selftest_timing_pkg::IDLE_CFG_ADDR);
    assign selftest_active = (selftest_axis_select != selftest_timing_pkg::AXIS_OFF); // [R5]
    assign sample_ext      = {{12{sample_in[15]}}, sample_in};
    assign last_sample     = (cnt_ff + 13'h0001 >= target); // [R3]
    assign phase_samples   = target;
    assign phase_sum       = sum_ff;
    assign phase_done      = done_ff;
    assign sample_tick     = tick;

    // The user settings are only masked, never stored, so they come back unchanged in the
    // same cycle in which the axis select returns to zero.
    always_comb
    begin
        if (selftest_active)
        begin
            output_data_rate = 4'h0; // [R4]
            power_mode       = 2'h0; // [R4]
        end
        else
        begin
            output_data_rate = user_output_data_rate; // [R5]
            power_mode       = user_power_mode; // [R5]
        end
    end

    selftest_sample_tick u_tick (
        .clk       (clk),
        .resetn    (resetn),
        .run       (selftest_active),
        .idle_code (idle_code),
        .tick      (tick)
    );

    always_comb
    begin
        if (dec_code > selftest_timing_pkg::DEC_MAX_CODE)
        begin
            // Codes above 12 saturate so the counter never needs a 14th bit.
            target = 13'h0001 << selftest_timing_pkg::DEC_MAX_CODE; // [R2]
        end
        else
        begin
            target = 13'h0001 << dec_code; // [R2]
        end
    end

    always_comb
    begin
        nxt_self_test_decimation_cfg = self_test_decimation_cfg_ff;
        nxt_idle_cfg                 = idle_cfg_ff;
        if (dec_cfg_sel)
        begin
            // Bits 7:4 are kept and read back although only the low nibble is used.
            nxt_self_test_decimation_cfg = reg_wdata; // [R1]
        end
        if (idle_cfg_sel)
        begin
            nxt_idle_cfg = {3'h0, reg_wdata[4:0]}; // [R6]
        end
    end

    always_comb
    begin
        case (reg_addr)
            selftest_timing_pkg::DEC_CFG_ADDR:
                reg_rdata = self_test_decimation_cfg_ff;
            selftest_timing_pkg::IDLE_CFG_ADDR:
                reg_rdata = idle_cfg_ff;
            default:
                reg_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            self_test_decimation_cfg_ff <= selftest_timing_pkg::DEC_CFG_RESET;
            idle_cfg_ff                 <= selftest_timing_pkg::IDLE_CFG_RESET;
        end
        else
        begin
            self_test_decimation_cfg_ff <= nxt_self_test_decimation_cfg;
            idle_cfg_ff                 <= nxt_idle_cfg;
        end
    end

    // Phase length is target slots of (base + idle*step), matching the period equation.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_acc   = acc_ff;
        nxt_sum   = sum_ff;
        nxt_done  = 1'b0;
        case (state_ff)
            PH_OFF:
            begin
                nxt_cnt = 13'h0000;
                nxt_acc = 28'h0000000;
                if (selftest_active)
                    nxt_state = PH_MEASURE;
            end
            PH_MEASURE, PH_RESULT:
            begin
                if (!selftest_active)
                begin
                    // A half-filled phase is dropped, so a restart always begins clean.
                    nxt_state = PH_OFF;
                    nxt_cnt   = 13'h0000;
                    nxt_acc   = 28'h0000000;
                end
                else if (tick && last_sample)
                begin
                    nxt_state = PH_RESULT;
                    nxt_sum   = acc_ff + sample_ext; // [R7]
                    nxt_done  = 1'b1;
                    nxt_cnt   = 13'h0000;
                    nxt_acc   = 28'h0000000;
                end
                else if (tick)
                begin
                    nxt_state = PH_MEASURE;
                    nxt_cnt   = cnt_ff + 13'h0001;
                    nxt_acc   = acc_ff + sample_ext; // [R7]
                end
                else
                begin
                    nxt_state = PH_MEASURE;
                end
            end
            default:
            begin
                nxt_state = PH_OFF;
                nxt_cnt   = 13'h0000;
                nxt_acc   = 28'h0000000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= PH_OFF;
            cnt_ff   <= 13'h0000;
            acc_ff   <= 28'h0000000;
            sum_ff   <= 28'h0000000;
            done_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            acc_ff   <= nxt_acc;
            sum_ff   <= nxt_sum;
            done_ff  <= nxt_done;
        end
    end
endmodule : selftest_timing
`default_nettype wire

/* test/selftest_timing_monitor.sv */
// Purpose: Port checker for the self-test timing block.
// Assumes: One clock domain, reset active low.
// Notes: Attached to every instance by the bind below.
`timescale 1ns/1ps
`default_nettype none
module selftest_timing_monitor (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic [1:0]  selftest_axis_select,
    input wire logic [3:0]  user_output_data_rate,
    input wire logic [1:0]  user_power_mode,
    input wire logic [15:0] sample_in,
    input wire logic [3:0]  output_data_rate,
    input wire logic [1:0]  power_mode,
    input wire logic        selftest_active,
    input wire logic        sample_tick,
    input wire logic [12:0] phase_samples,
    input wire logic [27:0] phase_sum,
    input wire logic        phase_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_rate_override: assert property (selftest_axis_select != 2'h0 |->
        {output_data_rate, power_mode} == 6'h00) else $error("user rate not overridden");
    a_user_restore: assert property (selftest_axis_select == 2'h0 |->
        {output_data_rate, power_mode} == {user_output_data_rate, user_power_mode})
        else $error("user rate not restored");
    a_active_level: assert property (selftest_active == (selftest_axis_select != 2'h0))
        else $error("active flag wrong");
    a_count_table: assert property (reg_addr == 8'h38 |-> phase_samples ==
        (reg_rdata[3:0] > 4'hC ? 13'h1000 : 13'h1 << reg_rdata[3:0])) else $error("bad count");
    a_idle_no_tick: assert property (!selftest_active |-> !sample_tick)
        else $error("tick while inactive");
    a_done_cause: assert property (phase_done |-> $past(sample_tick))
        else $error("phase end without sample");
    a_done_pulse: assert property (phase_done |=> !phase_done)
        else $error("phase end too long");
    a_tick_spacing: assert property (sample_tick |=> !sample_tick [*8])
        else $error("ticks too close");
    a_dec_write_lands: assert property ((reg_wr && reg_addr == 8'h38) ##1
        (reg_addr == 8'h38) |-> reg_rdata == $past(reg_wdata)) else $error("write lost");
    a_idle_write_lands: assert property ((reg_wr && reg_addr == 8'h37) ##1
        (reg_addr == 8'h37) |-> reg_rdata == {3'h0, $past(reg_wdata[4:0])})
        else $error("idle write lost");
    a_sum_holds: assert property (!phase_done |-> $stable(phase_sum))
        else $error("sum changed without phase end");
endmodule : selftest_timing_monitor
bind selftest_timing selftest_timing_monitor i_mon (
    .clk                   (clk),
    .resetn                (resetn),
    .reg_addr              (reg_addr),
    .reg_wr                (reg_wr),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata),
    .selftest_axis_select  (selftest_axis_select),
    .user_output_data_rate (user_output_data_rate),
    .user_power_mode       (user_power_mode),
    .sample_in             (sample_in),
    .output_data_rate      (output_data_rate),
    .power_mode            (power_mode),
    .selftest_active       (selftest_active),
    .sample_tick           (sample_tick),
    .phase_samples         (phase_samples),
    .phase_sum             (phase_sum),
    .phase_done            (phase_done)
);
`default_nettype wire

/* test/tb.sv */
// Purpose: Register and phase timing tests for the self-test timing block.
// Assumes: Inputs change at the falling edge; outputs read 1 ns later.
// Notes: Short phases only, so the run stays near 40k cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, resetn, reg_wr, selftest_active, sample_tick, phase_done;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [1:0]  selftest_axis_select, user_power_mode, power_mode;
    logic [3:0]  user_output_data_rate, output_data_rate;
    logic [15:0] sample_in;
    logic [12:0] phase_samples;
    logic [27:0] phase_sum;
    int          mismatches = 0;
    int          check_count = 0;
    logic [12:0] exp_count;
    selftest_timing i_dut (
        .clk                   (clk),
        .resetn                (resetn),
        .reg_addr              (reg_addr),
        .reg_wr                (reg_wr),
        .reg_wdata             (reg_wdata),
        .reg_rdata             (reg_rdata),
        .selftest_axis_select  (selftest_axis_select),
        .user_output_data_rate (user_output_data_rate),
        .user_power_mode       (user_power_mode),
        .sample_in             (sample_in),
        .output_data_rate      (output_data_rate),
        .power_mode            (power_mode),
        .selftest_active       (selftest_active),
        .sample_tick           (sample_tick),
        .phase_samples         (phase_samples),
        .phase_sum             (phase_sum),
        .phase_done            (phase_done)
    );
    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t saw %0h wanted %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    // A phase of 2**dec slots must yield that many ticks, evenly spaced, and their sum.
    task automatic run_phase(input logic [3:0] dec, input logic [4:0] idle);
        int c;
        int n;
        int last;
        int slot;
        wr(8'h38, {4'h0, dec});
        wr(8'h37, {3'h0, idle});
        {sample_in, selftest_axis_select, n, last} = {16'h0005, 2'h1, 64'h0};
        slot = 12500 + 1250 * int'(idle);
        #1 chk({output_data_rate, power_mode}, 6'h00);
        for (c = 0; c < 40000 && phase_done !== 1'b1; c++)
        begin
            @(negedge clk);
            #1 if (sample_tick === 1'b1 && n > 0)
                chk(28'(c - last), 28'(slot));
            if (sample_tick === 1'b1)
            begin
                n++;
                last = c;
            end
        end
        if (c >= 40000)
        begin
            mismatches++;
            return;
        end
        chk(28'(c), 28'((1 << dec) * slot));
        chk(28'(n), 28'(1 << dec));
        chk(phase_sum, 28'(5 << dec));
        @(negedge clk);
        selftest_axis_select = 2'h0;
        #1 chk({output_data_rate, power_mode}, 6'h2B);
    endtask : run_phase
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        {resetn, reg_wr, reg_addr, reg_wdata, selftest_axis_select, sample_in} = '0;
        {user_output_data_rate, user_power_mode} = 6'h2B;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        reg_addr = 8'h38;
        #1 chk({reg_rdata, phase_samples}, 21'h1);
        reg_addr = 8'h37;
        #1 chk(reg_rdata, 8'h00);
        reg_addr = 8'h39;
        #1 chk(reg_rdata, 8'h00);
        for (int k = 0; k < 16; k++)
        begin
            wr(8'h38, 8'hF0 | 8'(k));
            exp_count = (k > 12) ? 13'h1000 : 13'h0001 << k;
            #1 chk({reg_rdata, phase_samples}, {8'hF0 | 8'(k), exp_count});
        end
        wr(8'h37, 8'hFF);
        #1 chk(reg_rdata, 8'h1F);
        run_phase(4'h0, 5'h00);
        run_phase(4'h1, 5'h01);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
